// *** adcctl_top.sv ***
`timescale 1ns/100ps
`include "adcctl_defs.svh"
module adcctl_top import adcctl_pkg::*; (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // register port
  input  wire adcctl_bus_t   i_bus,
  output logic [7:0]         o_rdata,
  // trigger sources
  input  wire logic          i_pwm0_pin,
  input  wire logic          i_tmr_ovf,
  // analog front end
  output logic               o_conv_power,
  output logic               o_conv_start,
  output adcctl_route_t      o_route,
  output logic [10:0]        o_pin_analog,
  input  wire logic          i_conv_done,
  input  wire logic [11:0]   i_conv_data
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  adcctl_state_t state_reg;
  logic [7:0]    ctl0_reg;
  logic [7:0]    ctl1_reg;
  logic [1:0]    ts_reg;
  logic          retrig_reg;
  logic [2:0]    cnt_sel_reg;
  logic          run_reg;
  logic [4:0]    leb_reg;
  logic [5:0]    pair1_reg;
  logic [4:0]    pair2_reg;
  logic [3:0]    gap_sel_reg;
  logic [7:0]    trigger_counter_control_reg;
  logic [7:0]    trigger_counter_high_reg;
  logic [7:0]    trigger_counter_low_reg;
  logic [11:0]   result_reg;
  logic [15:0]   acc1_reg;
  logic [15:0]   acc2_reg;
  logic          busy_reg;
  logic          done_reg;
  logic [4:0]    grp_cnt_reg;
  logic [11:0]   tmr_reg;
  logic [2:0]    pwm_sync_reg;
  logic          pwm_lvl_reg;
  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire wr_c0   = i_bus.wr && (i_bus.addr == `A_CTL0);
  wire wr_c1   = i_bus.wr && (i_bus.addr == `A_CTL1);
  wire wr_auto = i_bus.wr && (i_bus.addr == `A_AUTO);
  wire wr_blk  = i_bus.wr && (i_bus.addr == `A_BLANK);
  wire wr_p1   = i_bus.wr && (i_bus.addr == `A_PAIR1);
  wire wr_p2   = i_bus.wr && (i_bus.addr == `A_PAIR2);
  wire wr_gap  = i_bus.wr && (i_bus.addr == `A_GAP);
  wire wr_tcc  = i_bus.wr && (i_bus.addr == `A_TRIGGER_COUNTER_CONTROL);
  wire wr_tch  = i_bus.wr && (i_bus.addr == `A_TRIGGER_COUNTER_HIGH);
  wire wr_tcl  = i_bus.wr && (i_bus.addr == `A_TRIGGER_COUNTER_LOW);
  wire wr_stat = i_bus.wr && (i_bus.addr == `A_STAT);
  wire [7:0] wd = i_bus.wdata;
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire en        = ctl0_reg[`B_EN];
  wire auto_mode = (cnt_sel_reg != `CNT_MAN);
  wire dual      = auto_mode && pair1_reg[`B_DUAL];
  wire fmt_eff   = ctl0_reg[`B_FMT] || auto_mode;
  wire idle      = (state_reg == ST_IDLE);
  // group size from count code; codes five and up all mean sixteen
  wire [4:0] grp_n = (cnt_sel_reg >= `CNT_FULL) ? `GRP_MAX :
                     5'(5'h01 << (cnt_sel_reg - 3'h1));
  // manual start on the high-to-low write of the start bit
  wire man_go = wr_c0 && ctl0_reg[`B_START] && !wd[`B_START]
                && !auto_mode && en && idle;
  // ----------------------------------------
  // trigger selection
  // ----------------------------------------
  wire run_rise = wr_blk && wd[`B_RUN] && !run_reg;
  wire pwm_agree = (pwm_sync_reg[1] == pwm_sync_reg[2]);
  wire pwm_rise  = pwm_agree && pwm_sync_reg[1] && !pwm_lvl_reg;
  // both timer sources arrive as one overflow pulse from the timer
  wire trig_raw = (ts_reg == `TS_PWM) ? pwm_rise :
                  (ts_reg == `TS_SW)  ? run_rise : i_tmr_ovf;
  // arming counts at once, so the software source fires on its own edge
  wire trig = trig_raw && (run_reg || run_rise) && auto_mode && en;
  // ----------------------------------------
  // conversion completion
  // ----------------------------------------
  wire ch1_done = (state_reg == ST_CH1) && i_conv_done;
  wire ch2_done = (state_reg == ST_CH2) && i_conv_done;
  wire conv_end = (ch1_done && !dual) || ch2_done;
  wire grp_last = conv_end && auto_mode
                  && (grp_cnt_reg + 5'h01 == grp_n);
  wire tmr_end  = (tmr_reg == 12'h001);
  wire [11:0] leb_cyc = 12'(({7'h00, leb_reg} + 12'h001) * `LEB_UNIT_CYC);
  wire [11:0] gap_cyc = 12'(({8'h00, gap_sel_reg} + 12'h001) * `GAP_UNIT_CYC);
  // ----------------------------------------
  // input routing
  // ----------------------------------------
  function automatic adcctl_route_t route_std(input logic [2:0] ins,
                                              input logic [3:0] ch);
    adcctl_route_t r;
    r = '0;
    if ((ins >= 3'h1) && (ins <= 3'h4)) begin
      r.int_src = 2'(ins - 3'h1);
    end else begin
      r.ext_en = (ch <= `MAX_EXT);
      r.ext_ch = ch;
    end
    return r;
  endfunction : route_std
  function automatic adcctl_route_t route_pair(input logic [4:0] sel);
    adcctl_route_t r;
    r = '0;
    if (sel[`B_SS]) begin
      r.ext_en = (sel[3:0] <= `MAX_EXT);
      r.ext_ch = sel[3:0];
    end else if (sel[3:0] <= 4'h3) begin
      r.int_src = sel[1:0];
    end
    return r;
  endfunction : route_pair
  // pair routing in dual mode, shared selects otherwise
  wire ch2_phase = (state_reg == ST_GAP) || (state_reg == ST_CH2);
  wire adcctl_route_t route_sel =
    !dual     ? route_std(ctl1_reg[7:5], ctl0_reg[3:0]) :
    ch2_phase ? route_pair(pair2_reg) :
                route_pair(pair1_reg[4:0]);
  // pin takeover mask: drops shared function and pull-up
  wire [10:0] pin_next = (route_sel.ext_en && en) ?
                         11'(11'h001 << route_sel.ext_ch) : 11'h000;
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [7:0] res_hi = fmt_eff ? {4'h0, result_reg[11:8]} :
                                result_reg[11:4];
  wire [7:0] res_lo = fmt_eff ? result_reg[7:0] :
                                {result_reg[3:0], 4'h0};
  wire [7:0] c0_rd = {ctl0_reg[7], busy_reg, ctl0_reg[5],
                      fmt_eff, ctl0_reg[3:0]};
  logic [7:0] rd_val;
  always_comb begin
    case (i_bus.addr)
      `A_RES_LO: rd_val = res_lo;
      `A_RES_HI: rd_val = res_hi;
      `A_ACC1_H: rd_val = acc1_reg[15:8];
      `A_ACC1_L: rd_val = acc1_reg[7:0];
      `A_ACC2_H: rd_val = acc2_reg[15:8];
      `A_ACC2_L: rd_val = acc2_reg[7:0];
      `A_CTL0:   rd_val = c0_rd;
      `A_CTL1:   rd_val = ctl1_reg;
      `A_AUTO:   rd_val = {ts_reg, 1'b0, retrig_reg, 1'b0, cnt_sel_reg};
      `A_BLANK:  rd_val = {run_reg, 2'h0, leb_reg};
      `A_PAIR1:  rd_val = {2'h0, pair1_reg};
      `A_PAIR2:  rd_val = {3'h0, pair2_reg};
      `A_GAP:    rd_val = {4'h0, gap_sel_reg};
      `A_TRIGGER_COUNTER_CONTROL:   rd_val = trigger_counter_control_reg;
      `A_TRIGGER_COUNTER_HIGH:   rd_val = trigger_counter_high_reg;
      `A_TRIGGER_COUNTER_LOW:   rd_val = trigger_counter_low_reg;
      `A_STAT:   rd_val = {7'h00, done_reg};
      default:   rd_val = `R8_ZERO;
    endcase
  end
  // ----------------------------------------
  // trigger pin synchroniser
  // ----------------------------------------
  // level only moves once stages two and three agree, so a glitch
  // caught by the first stage cannot fire a conversion
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwm_sync_reg <= 3'h0;
      pwm_lvl_reg  <= 1'b0;
    end else begin
      pwm_sync_reg <= {pwm_sync_reg[1:0], i_pwm0_pin};
      if (pwm_agree) begin
        pwm_lvl_reg <= pwm_sync_reg[1];
      end
    end
  end
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl0_reg    <= `R8_ZERO;
      ctl1_reg    <= `R8_ZERO;
      ts_reg      <= 2'h0;
      cnt_sel_reg <= 3'h0;
      leb_reg     <= 5'h00;
      pair1_reg   <= 6'h00;
      pair2_reg   <= 5'h00;
      gap_sel_reg <= 4'h0;
      trigger_counter_control_reg    <= `R8_ZERO;
      trigger_counter_high_reg    <= `R8_ZERO;
      trigger_counter_low_reg    <= `R8_ZERO;
    end else begin
      if (wr_c0)   ctl0_reg    <= {wd[7], 1'b0, wd[5:0]};
      if (wr_c1)   ctl1_reg    <= wd;
      if (wr_auto) ts_reg      <= wd[7:6];
      if (wr_auto) cnt_sel_reg <= wd[2:0];
      if (wr_blk)  leb_reg     <= wd[4:0];
      if (wr_p1)   pair1_reg   <= wd[5:0];
      if (wr_p2)   pair2_reg   <= wd[4:0];
      if (wr_gap)  gap_sel_reg <= wd[3:0];
      if (wr_tcc)  trigger_counter_control_reg    <= wd;
      if (wr_tch)  trigger_counter_high_reg    <= wd;
      if (wr_tcl)  trigger_counter_low_reg    <= wd;
    end
  end
  // ----------------------------------------
  // hardware-touched flags
  // ----------------------------------------
  // hardware set beats a software clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_reg    <= 1'b0;
      retrig_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      if (grp_last)    run_reg <= 1'b0;
      else if (wr_blk) run_reg <= wd[`B_RUN];
      if (trig && busy_reg)      retrig_reg <= 1'b1;
      else if (run_rise)         retrig_reg <= 1'b0;
      else if (wr_auto)          retrig_reg <= retrig_reg && wd[`B_RETRIG];
      if (grp_last)              done_reg <= 1'b1;
      else if (wr_stat && wd[`B_DONE]) done_reg <= 1'b0;
    end
  end
  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg    <= ST_IDLE;
      busy_reg     <= 1'b0;
      tmr_reg      <= 12'h000;
      grp_cnt_reg  <= 5'h00;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      if (run_rise) grp_cnt_reg <= 5'h00;
      if (!en) begin
        // switching off abandons a conversion in flight
        state_reg <= ST_IDLE;
        busy_reg  <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (man_go || (trig && ts_reg != `TS_PWM)) begin
              state_reg    <= ST_CH1;
              busy_reg     <= 1'b1;
              o_conv_start <= 1'b1;
            end else if (trig) begin
              state_reg <= ST_BLANK;
              tmr_reg   <= leb_cyc;
            end
          end
          ST_BLANK: begin
            if (!run_reg) begin
              state_reg <= ST_IDLE;
            end else if (tmr_end) begin
              state_reg    <= ST_CH1;
              busy_reg     <= 1'b1;
              o_conv_start <= 1'b1;
            end else begin
              tmr_reg <= tmr_reg - 12'h001;
            end
          end
          ST_CH1: begin
            if (i_conv_done) begin
              busy_reg <= 1'b0;
              if (dual) begin
                state_reg <= ST_GAP;
                tmr_reg   <= gap_cyc;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_GAP: begin
            if (!run_reg) begin
              state_reg <= ST_IDLE;
            end else if (tmr_end) begin
              state_reg    <= ST_CH2;
              busy_reg     <= 1'b1;
              o_conv_start <= 1'b1;
            end else begin
              tmr_reg <= tmr_reg - 12'h001;
            end
          end
          ST_CH2: begin
            if (i_conv_done) begin
              busy_reg  <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
          end
        endcase
        if (conv_end && auto_mode) grp_cnt_reg <= 5'(grp_cnt_reg + 5'h01);
      end
    end
  end
  // ----------------------------------------
  // result and accumulators
  // ----------------------------------------
  // result only moves while enabled, so a disabled converter holds it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      result_reg <= 12'h000;
    end else if (en && (ch1_done || ch2_done)) begin
      result_reg <= i_conv_data;
    end
  end
  // no reset: the buffers have no defined power-on contents
  always_ff @(posedge i_clk) begin
    if (run_rise) begin
      acc1_reg <= 16'h0000;
      acc2_reg <= 16'h0000;
    end else if (en && auto_mode) begin
      if (ch1_done) acc1_reg <= 16'(acc1_reg + {4'h0, i_conv_data});
      if (ch2_done) acc2_reg <= 16'(acc2_reg + {4'h0, i_conv_data});
    end
  end
  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata      <= `R8_ZERO;
      o_conv_power <= 1'b0;
      o_route      <= '0;
      o_pin_analog <= 11'h000;
    end else begin
      o_rdata      <= i_bus.rd ? rd_val : `R8_ZERO;
      o_conv_power <= en;
      o_route      <= route_sel;
      o_pin_analog <= pin_next;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_arm_auto;
    trig && idle && (ts_reg != `TS_PWM);
  endsequence
  sequence s_arm_blank;
    trig && idle && (ts_reg == `TS_PWM);
  endsequence
  a_manual_start: assert property (man_go |=> o_conv_start && busy_reg)
    else $error("manual start missed");
  a_start_ignored: assert property (wr_c0 && auto_mode && idle && !trig |=> !o_conv_start)
    else $error("start bit acted in auto mode");
  a_auto_trigger: assert property (s_arm_auto |=> o_conv_start)
    else $error("auto trigger did not start");
  a_blank_wait: assert property (s_arm_blank |=> (!o_conv_start)[*8])
    else $error("blanking skipped");
  a_busy_clear: assert property (busy_reg && i_conv_done && en |=> !busy_reg)
    else $error("busy not cleared");
  a_route_int: assert property (!dual && ctl1_reg[7:5] == 3'h1 |=> !o_route.ext_en)
    else $error("external channel left on");
  a_result_hold: assert property (!en |=> $stable(result_reg))
    else $error("result changed while disabled");
  a_fmt_forced: assert property (i_bus.rd && i_bus.addr == `A_RES_HI && auto_mode
                                 |=> o_rdata[7:4] == 4'h0)
    else $error("auto format not forced");
  a_group_end: assert property (grp_last |=> !run_reg && done_reg)
    else $error("group end not flagged");
  a_retrig_set: assert property (trig && busy_reg |=> retrig_reg)
    else $error("retrigger not flagged");

endmodule : adcctl_top

// *** adcctl_defs.svh ***
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define A_RES_LO  5'h00
`define A_RES_HI  5'h01
`define A_ACC1_H  5'h02
`define A_ACC1_L  5'h03
`define A_ACC2_H  5'h04
`define A_ACC2_L  5'h05
`define A_CTL0    5'h06
`define A_CTL1    5'h07
`define A_AUTO    5'h08
`define A_BLANK   5'h09
`define A_PAIR1   5'h0A
`define A_PAIR2   5'h0B
`define A_GAP     5'h0C
`define A_TRIGGER_COUNTER_CONTROL    5'h0D
`define A_TRIGGER_COUNTER_HIGH    5'h0E
`define A_TRIGGER_COUNTER_LOW    5'h0F
`define A_STAT    5'h10
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define B_START   7
`define B_BUSY    6
`define B_EN      5
`define B_FMT     4
`define B_RUN     7
`define B_RETRIG  4
`define B_DUAL    5
`define B_SS      4
`define B_DONE    0
`define CNT_MAN   3'h0
`define CNT_FULL  3'h5
`define GRP_MAX   5'h10
`define MAX_EXT   4'hA
`define TS_PWM    2'h0
`define TS_SW     2'h3
`define R8_ZERO   8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS      8
`define LEB_UNIT_NS 500
`define GAP_UNIT_NS 1000
`define LEB_UNIT_CYC ((`LEB_UNIT_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_UNIT_CYC ((`GAP_UNIT_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// *** adcctl_pkg.sv ***
package adcctl_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_BLANK, ST_CH1, ST_GAP, ST_CH2
  } adcctl_state_t;
  // analog input routing to the converter
  typedef struct packed {
    logic       ext_en;
    logic [3:0] ext_ch;
    logic [1:0] int_src;
  } adcctl_route_t;
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } adcctl_bus_t;
endpackage : adcctl_pkg

// *** adcctl_front_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// analog front end stand-in
// ----------------------------------------
module adcctl_front_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // converter handshake
  input  wire logic        i_start,
  input  wire logic [7:0]  i_lat,
  input  wire logic [11:0] i_value,
  output logic             o_done,
  output logic [11:0]      o_data
);
  logic [7:0]  cnt_reg;
  logic        act_reg;
  logic [11:0] last_reg;

  // one answer per start, i_lat + 1 cycles after the start is sampled, never unprompted
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      act_reg  <= 1'b0;
      cnt_reg  <= 8'h00;
      o_done   <= 1'b0;
      last_reg <= 12'h000;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        act_reg <= 1'b1;
        cnt_reg <= i_lat;
      end else if (act_reg && cnt_reg == 8'h00) begin
        act_reg  <= 1'b0;
        o_done   <= 1'b1;
        last_reg <= i_value;
      end else if (act_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  // result lines are only meaningful with done, so show junk otherwise
  assign o_data = o_done ? last_reg : ~last_reg;
endmodule : adcctl_front_model

// *** test_adcctl_top.sv ***
`timescale 1ns/100ps
`include "adcctl_defs.svh"
module test_adcctl_top import adcctl_pkg::*;;
  logic          i_clk;
  logic          i_rst;
  adcctl_bus_t   bus;
  logic [7:0]    rdata;
  logic          ovf;
  logic          pwm;
  logic          power;
  logic          start;
  adcctl_route_t route;
  adcctl_route_t rt;
  logic [10:0]   pin;
  logic          done;
  logic [11:0]   data;
  logic [7:0]    lat;
  logic [11:0]   val;
  int            bad_count, compares, starts, dones, cyc, st_cyc, dn_cyc;

  adcctl_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
    .i_pwm0_pin(pwm), .i_tmr_ovf(ovf), .o_conv_power(power), .o_conv_start(start),
    .o_route(route), .o_pin_analog(pin), .i_conv_done(done), .i_conv_data(data));
  adcctl_front_model fe (.i_clk(i_clk), .i_rst(i_rst), .i_start(start), .i_lat(lat),
    .i_value(val), .o_done(done), .o_data(data));

  // ----------------------------------------
  // clock, monitor, shared tasks
  // ----------------------------------------
  always #4 i_clk = ~i_clk;

  // route is captured at the start pulse, when the converter samples it
  always @(posedge i_clk) begin
    cyc++;
    if (start === 1'b1) begin
      starts++;
      st_cyc = cyc;
      rt = route;
    end
    if (done === 1'b1) begin
      dones++;
      dn_cyc = cyc;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge i_clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clk);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask : rd

  task automatic pulse;
    @(posedge i_clk);
    ovf <= 1'b1;
    @(posedge i_clk);
    ovf <= 1'b0;
  endtask : pulse

  // bounded wait; one spare edge lets busy drop before the next trigger
  task automatic wait_for(ref int c, input int n);
    int k;
    k = 0;
    while (c < n && k < 3000) begin
      @(posedge i_clk);
      k++;
    end
    check(16'(c), 16'(n));
    @(posedge i_clk);
  endtask : wait_for

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    rd(`A_CTL0, d);
    check(d, `R8_ZERO);
    wr(`A_BLANK, 8'h1F);
    rd(`A_BLANK, d);
    check(d, 8'h1F);
    wr(`A_GAP, 8'h0F);
    rd(`A_GAP, d);
    check(d, 8'h0F);
    wr(5'h1F, 8'hFF);
    rd(5'h1F, d);
    check(d, 8'h00);
    wr(`A_BLANK, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_manual;
    logic [7:0] d;
    int s0;
    s0 = starts;
    lat <= 8'd30;
    val <= 12'hABC;
    wr(`A_CTL1, 8'h00);
    wr(`A_CTL0, 8'hA3);
    repeat (4) @(posedge i_clk);
    check(16'(starts), 16'(s0));
    wr(`A_CTL0, 8'h23);
    wait_for(starts, s0 + 1);
    rd(`A_CTL0, d);
    check(d, 8'h63);
    check({rt.ext_en, rt.ext_ch}, 5'h13);
    wait_for(dones, dones + 1);
    rd(`A_CTL0, d);
    check(d, 8'h23);
    rd(`A_RES_HI, d);
    check(d, 8'hAB);
    rd(`A_RES_LO, d);
    check(d, 8'hC0);
    wr(`A_CTL0, 8'h33);
    rd(`A_RES_HI, d);
    check(d, 8'h0A);
    rd(`A_RES_LO, d);
    check(d, 8'hBC);
    check(pin, 11'h008);
    // disabled converter must neither start nor touch the result
    wr(`A_CTL0, 8'h13);
    wr(`A_CTL0, 8'h93);
    wr(`A_CTL0, 8'h13);
    repeat (4) @(posedge i_clk);
    check(power, 1'b0);
    check(16'(starts), 16'(s0 + 1));
    rd(`A_RES_LO, d);
    check(d, 8'hBC);
    $display("test manual done");
  endtask : t_manual

  task automatic t_internal;
    wr(`A_CTL0, 8'h20);
    for (int k = 1; k <= 4; k++) begin
      wr(`A_CTL1, {3'(k), 5'h00});
      repeat (2) @(posedge i_clk);
      check({route.ext_en, route.int_src}, {1'b0, 2'(k - 1)});
    end
    wr(`A_CTL1, 8'h00);
    $display("test internal done");
  endtask : t_internal

  task automatic t_auto;
    logic [7:0]  d;
    logic [11:0] v;
    logic [15:0] sum;
    int n;
    lat <= 8'd12;
    for (int c = 1; c <= 7; c++) begin
      n = (c >= 5) ? 16 : (1 << (c - 1));
      v = 12'h800 + 12'(c) * 12'h0F1;
      sum = 16'(n) * {4'h0, v};
      val <= v;
      wr(`A_STAT, 8'h01);
      wr(`A_AUTO, {5'b01000, 3'(c)});
      wr(`A_BLANK, 8'h80);
      for (int i = 0; i < n; i++) begin
        pulse();
        wait_for(dones, dones + 1);
      end
      rd(`A_BLANK, d);
      check(d[7], 1'b0);
      rd(`A_STAT, d);
      check(d[0], 1'b1);
      rd(`A_ACC1_H, d);
      check(d, sum[15:8]);
      rd(`A_ACC1_L, d);
      check(d, sum[7:0]);
      rd(`A_RES_HI, d);
      check(d, {4'h0, v[11:8]});
    end
    $display("test auto done");
  endtask : t_auto

  task automatic t_retrig;
    logic [7:0] d;
    int s0;
    int d0;
    s0 = starts;
    d0 = dones;
    lat <= 8'd60;
    wr(`A_AUTO, 8'h42);
    wr(`A_CTL0, 8'hA0);
    wr(`A_CTL0, 8'h20);
    repeat (4) @(posedge i_clk);
    check(16'(starts), 16'(s0));
    wr(`A_BLANK, 8'h80);
    pulse();
    wait_for(starts, s0 + 1);
    pulse();
    wait_for(dones, d0 + 1);
    check(16'(starts), 16'(s0 + 1));
    rd(`A_AUTO, d);
    check(d[4], 1'b1);
    pulse();
    wait_for(dones, d0 + 2);
    wr(`A_BLANK, 8'h80);
    rd(`A_AUTO, d);
    check(d[4], 1'b0);
    wr(`A_BLANK, 8'h00);
    $display("test retrigger done");
  endtask : t_retrig

  // software source fires on arming; pwm0 edge waits out the blanking
  task automatic t_trig;
    int s0;
    int c0;
    int w;
    s0 = starts;
    lat <= 8'd8;
    wr(`A_AUTO, 8'hC1);
    wr(`A_BLANK, 8'h80);
    wait_for(starts, s0 + 1);
    wait_for(dones, dones + 1);
    wr(`A_AUTO, 8'h01);
    wr(`A_BLANK, 8'h81);
    pwm <= 1'b1;
    c0 = cyc;
    wait_for(starts, s0 + 2);
    // three sync stages, trigger edge, two blanking units, monitor edge
    w = st_cyc - c0;
    check(16'(w >= 2 * `LEB_UNIT_CYC + 4 && w <= 2 * `LEB_UNIT_CYC + 6), 16'h1);
    wait_for(dones, dones + 1);
    pwm <= 1'b0;
    repeat (8) @(posedge i_clk);
    pwm <= 1'b1;
    repeat (8) @(posedge i_clk);
    check(16'(starts), 16'(s0 + 2));
    pwm <= 1'b0;
    wr(`A_BLANK, 8'h00);
    $display("test trigger done");
  endtask : t_trig

  task automatic t_dual;
    logic [7:0] d;
    int s0;
    int d0;
    s0 = starts;
    d0 = dones;
    lat <= 8'd10;
    val <= 12'h5A5;
    wr(`A_AUTO, 8'h41);
    wr(`A_PAIR1, 8'h32);
    wr(`A_PAIR2, 8'h15);
    wr(`A_GAP, 8'h01);
    wr(`A_BLANK, 8'h80);
    pulse();
    wait_for(starts, s0 + 1);
    check({rt.ext_en, rt.ext_ch}, 5'h12);
    wait_for(dones, d0 + 1);
    val <= 12'h3C3;
    wait_for(starts, s0 + 2);
    check(16'(st_cyc - dn_cyc >= 250 && st_cyc - dn_cyc <= 253), 16'h1);
    check({rt.ext_en, rt.ext_ch}, 5'h15);
    wait_for(dones, d0 + 2);
    rd(`A_ACC1_L, d);
    check(d, 8'hA5);
    rd(`A_ACC2_H, d);
    check(d, 8'h03);
    rd(`A_ACC2_L, d);
    check(d, 8'hC3);
    $display("test dual done");
  endtask : t_dual

  task automatic stop_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // main sequence after a 12-cycle reset
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    bus = '0;
    ovf = 1'b0;
    pwm = 1'b0;
    lat = 8'd8;
    val = 12'h000;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_manual();
    t_internal();
    t_auto();
    t_retrig();
    t_trig();
    t_dual();
    stop_test();
  end

  // whole run needs about 2k cycles, so 50k is a safe ceiling
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
endmodule : test_adcctl_top
